//--- sim/adc_serial_chk.sv
// ****************************************
// serial front end checker
// ****************************************
module adc_serial_chk (
  input logic       clk,
  input logic       rst_b,
  input logic       cs_n,
  input logic       dout_oe,
  input logic       result_ready_n,
  input logic       clock_output,
  input logic       power_down,
  input logic [1:0] channel_sel,
  input logic       noise_eval,
  input logic       modulator_reset,
  input logic       result_settled
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_oe_cs_high: assert property (cs_n [*4] |-> !dout_oe)
    else $error("output enabled with chip select high");
  a_oe_cs_low: assert property (!cs_n [*6] |-> dout_oe)
    else $error("output not enabled with chip select low");
  a_pd_needs_cs: assert property ($changed(power_down) |-> dout_oe)
    else $error("power-down changed while deselected");
  a_ch_needs_cs: assert property ($changed(channel_sel) |-> dout_oe)
    else $error("channel changed while deselected");
  a_noise_code: assert property (1'b1 |=> noise_eval == ($past(channel_sel) == 2'h2))
    else $error("noise input flag does not follow channel code");
  a_pd_mod_reset: assert property (power_down [*2] |-> modulator_reset)
    else $error("modulator running in power-down");
  // a disable may cut a high phase short, so only the low phase is timed
  a_clock_output_gap: assert property ($fell(clock_output) |=> $stable(clock_output) [*8])
    else $error("clock output toggles too fast");
  a_ready_by_read: assert property ($rose(result_ready_n) |-> dout_oe)
    else $error("ready cleared without a serial read");
  a_ready_settled: assert property ($fell(result_ready_n) |-> ##[0:2] result_settled)
    else $error("result flagged before settling");
  a_held_no_result: assert property (modulator_reset [*5] |-> !$fell(result_ready_n))
    else $error("result completed while held in reset");
endmodule

bind adc_serial_register_access adc_serial_chk chk (
  .clk            (clk),
  .rst_b          (rst_b),
  .cs_n           (cs_n),
  .dout_oe        (dout_oe),
  .result_ready_n (result_ready_n),
  .clock_output   (clock_output),
  .power_down     (power_down),
  .channel_sel    (channel_sel),
  .noise_eval     (noise_eval),
  .modulator_reset(modulator_reset),
  .result_settled (result_settled)
);

//--- sim/host_master.sv
// ****************************************
// serial bus master model
// ****************************************
module host_master (
  input  logic clk,
  input  logic dout,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b1;
  end
  // m[0] selects during the frame, m[1] leaves select low after it
  // offset from clk so no link edge ever lands on a sampling edge
  task automatic xfer(input int n, input logic [31:0] w, input logic [1:0] m,
                      output logic [31:0] r);
    r = '0;
    @(posedge clk);
    #1.3;
    cs_n = ~m[0];
    #32;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din  = w[i];
      #32;
      sclk = 1'b1;
      r    = {r[30:0], dout};
      #32;
    end
    // no pull on the line: show the inverse rather than the last bit
    din  = ~din;
    cs_n = ~m[1];
  endtask
endmodule

//--- sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] conv_result = 16'hA5C3;
  logic [31:0] rv;
  logic        lvl;
  int          n;
  int          error_cnt = 0;
  int          cmp_count = 0;
  wire         cs_n, sclk, din, dout, dout_oe, result_ready_n, clock_output;
  wire         power_down, noise_eval, modulator_reset, result_settled;
  wire [1:0]   channel_sel;
  logic [2:0]  sel_t [5] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
  int          wid_t [5] = '{8, 8, 8, 24, 24};
  logic [23:0] rst_t [5] = '{24'h1, 24'h5, 24'h0, 24'h1F_4000, 24'h57_61AB};

  always #2.5 clk = ~clk;

  host_master host (.clk(clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));

  // conversion tick shortened so a full sync-to-result run stays short
  adc_serial_register_access #(.CONV_TICK_DIV(2)) dut (
    .clk(clk), .rst_b(rst_b), .cs_n(cs_n), .sclk(sclk), .din(din),
    .conv_result(conv_result), .dout(dout), .dout_oe(dout_oe),
    .result_ready_n(result_ready_n), .clock_output(clock_output),
    .power_down(power_down), .channel_sel(channel_sel), .noise_eval(noise_eval),
    .modulator_reset(modulator_reset), .result_settled(result_settled)
  );

  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [2:0] s, input logic r, input logic pd,
                     input logic [1:0] ch, input logic [1:0] m);
    host.xfer(8, {24'h0, 1'b0, s, r, pd, ch}, m, rv);
  endtask
  task automatic wr(input logic [2:0] s, input logic [1:0] ch, input int w,
                    input logic [23:0] v);
    cmd(s, 1'b0, 1'b0, ch, 2'h1);
    host.xfer(w, {8'h0, v}, 2'h1, rv);
  endtask
  task automatic rd(input string nm, input logic [2:0] s, input logic [1:0] ch,
                    input int w, input logic [23:0] e);
    cmd(s, 1'b1, 1'b0, ch, 2'h1);
    host.xfer(w, 32'h0, 2'h1, rv);
    chk(nm, {8'h0, e}, rv);
  endtask
  task automatic toggles(output int t);
    t = 0;
    lvl = clock_output;
    repeat (300) begin
      @(posedge clk);
      if (clock_output !== lvl)
        t++;
      lvl = clock_output;
    end
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    chk("oe", 0, dout_oe);
    chk("ready", 1, result_ready_n);
    chk("modrst", 1, modulator_reset);
    for (int i = 0; i < 5; i++)
      rd("reg", sel_t[i], 2'h0, wid_t[i], rst_t[i]);
    host.xfer(8, 32'h04, 2'h0, rv);
    chk("pd_ignored", 0, power_down);
    cmd(3'h0, 1'b0, 1'b1, 2'h0, 2'h1);
    chk("pd_on", 1, power_down);
    toggles(n);
    chk("clock_output_runs", 1, n > 5);
    cmd(3'h2, 1'b0, 1'b1, 2'h0, 2'h1);
    host.xfer(8, 32'h15, 2'h1, rv);
    toggles(n);
    chk("clock_output_off", 0, {n[30:0], clock_output});
    wr(3'h2, 2'h0, 8, 24'h7);
    chk("pd_off", 0, power_down);
    for (int c = 0; c < 4; c++) begin
      cmd(3'h0, 1'b0, 1'b0, c[1:0], 2'h1);
      repeat (2) @(posedge clk);
      chk("chan", c, channel_sel);
      chk("noise", c == 2, noise_eval);
    end
    wr(3'h6, 2'h1, 24, 24'h12_3456);
    rd("off0", 3'h6, 2'h0, 24, 24'h1F_4000);
    rd("off1", 3'h6, 2'h1, 24, 24'h12_3456);
    rd("off2", 3'h6, 2'h3, 24, 24'h1F_4000);
    host.xfer(32, 32'hFFFF_FFFF, 2'h1, rv);
    host.xfer(4, 32'hF, 2'h1, rv);
    rd("resync", 3'h1, 2'h0, 8, 24'h1);
    cmd(3'h5, 1'b0, 1'b0, 2'h0, 2'h1);
    cmd(3'h2, 1'b1, 1'b0, 2'h0, 2'h3);
    host.xfer(8, 32'h0, 2'h1, rv);
    chk("three_wire", 8'h07, rv);
    wr(3'h1, 2'h0, 8, 24'h0);
    chk("not_settled", 0, result_settled);
    n = 0;
    while (result_ready_n !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("sync_to_result", 1, n > 1170 && n < 1215);
    chk("settled", 1, result_settled);
    chk("running", 0, modulator_reset);
    rd("stat_ready", 3'h0, 2'h0, 8, 24'h08);
    wr(3'h1, 2'h0, 8, 24'h1);
    chk("ready_kept", 0, result_ready_n);
    chk("halted", 1, modulator_reset);
    chk("unsettled", 0, result_settled);
    rd("data", 3'h3, 2'h0, 16, 24'hA5C3);
    chk("ready_clear", 1, result_ready_n);
    rd("stat_read", 3'h0, 2'h0, 8, 24'h88);
    report_and_stop;
  end

  initial begin
    #200us;
    error_cnt++;
    report_and_stop;
  end
endmodule

//--- verilog/adc_serial_consts.vh
`ifndef ADC_SERIAL_CONSTS_VH
`define ADC_SERIAL_CONSTS_VH
// ****************************************
// register select codes
// ****************************************
`define SEL_COMM      3'h0
`define SEL_SETUP     3'h1
`define SEL_CLOCK     3'h2
`define SEL_DATA      3'h3
`define SEL_TEST      3'h4
`define SEL_NOOP      3'h5
`define SEL_OFFSET    3'h6
`define SEL_GAIN      3'h7
// ****************************************
// command byte fields
// ****************************************
`define CMD_START_BIT 7
`define CMD_SEL_HI    6
`define CMD_SEL_LO    4
`define CMD_DIR_BIT   3
`define CMD_PD_BIT    2
`define CMD_CH_HI     1
`define CMD_CH_LO     0
// ****************************************
// setup and clock register fields
// ****************************************
`define SETUP_SYNC_BIT  0
`define CLK_DIS_BIT     4
`define CLK_HALVE_BIT   3
`define CLK_RATE_HI     2
`define CLK_RATE_LO     0
`define CLK_WR_MASK     8'h1F
// ****************************************
// reset values and widths
// ****************************************
`define RST_SETUP     8'h01
`define RST_CLOCK     8'h05
`define RST_OFFSET    24'h1F_4000
`define RST_GAIN      24'h57_61AB
`define LEN_BYTE      5'h08
`define LEN_HALF      5'h10
`define LEN_WORD      5'h18
`define ONES_RESYNC   6'h20
// ****************************************
// timing: output period in conversion ticks
// ****************************************
`define CONV_TICK_NS  10000
`define SETTLE_SYNC   2'h3
`define SETTLE_FREE   3'h4
`define ODR_P0        13'h1388
`define ODR_P1        13'h0FA0
`define ODR_P2        13'h03E8
`define ODR_P3        13'h01F4
`define ODR_P4        13'h07D0
`define ODR_P5        13'h0683
`define ODR_P6        13'h0190
`define ODR_P7        13'h00C8
`endif

//--- verilog/adc_serial_register_access.v
// Functional notes
// [R1] sample data in on sclk rise, cs low
// [R2] change data out on sclk fall
// [R3] all words shifted msb first
// [R4] cs high: output off, pins ignored
// [R5] host may tie cs low permanently
// [R6] seven registers of 8, 16, 24 bits
// [R7] idle expects a command byte write
// [R8] command byte then selected register transfer
// [R9] back to idle after the transfer
// [R10] 32 ones abandon transfer, keep registers
// [R11] leading one bits are skipped, not loaded
// [R12] status top bit mirrors ready pin
// [R13] select field picks the next register
// [R14] select code map and reset values
// [R15] direction bit: 0 write, 1 read
// [R16] power-down bit enters and leaves power-down
// [R17] clock output runs in power-down unless disabled
// [R18] channel bits pick input and coefficient pair
// [R19] code 10 selects noise evaluation input
// [R20] output rate from clock and rate bits
// [R21] free step settles within four periods
// [R22] first result three periods after sync falls
// [R23] sync high stops and resets conversion
// [R24] only a data read clears ready
// [R25] data phase length equals register width
`include "adc_serial_consts.vh"

module adc_serial_register_access #(
  parameter CLK_PERIOD_NS = 5,
  parameter CONV_TICK_DIV = `CONV_TICK_NS / CLK_PERIOD_NS,
  parameter CLOCK_OUTPUT_HALF   = 41
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        cs_n,
  input  wire        sclk,
  input  wire        din,
  input  wire [15:0] conv_result,
  output reg         dout,
  output reg         dout_oe,
  output reg         result_ready_n,
  output reg         clock_output,
  output reg         power_down,
  output reg  [1:0]  channel_sel,
  output reg         noise_eval,
  output reg         modulator_reset,
  output reg         result_settled
);

  // ****************************************
  // functions
  // ****************************************
  function [4:0] reg_len; // [R6]
    input [2:0] sel;
    begin
      case (sel)
        `SEL_DATA:   reg_len = `LEN_HALF;
        `SEL_OFFSET: reg_len = `LEN_WORD;
        `SEL_GAIN:   reg_len = `LEN_WORD;
        `SEL_NOOP:   reg_len = 5'h00;
        default:     reg_len = `LEN_BYTE;
      endcase
    end
  endfunction

  function [1:0] pair_of;
    input [1:0] ch;
    begin
      case (ch)
        2'b01:   pair_of = 2'h1;
        2'b11:   pair_of = 2'h2;
        default: pair_of = 2'h0;
      endcase
    end
  endfunction

  function [12:0] period_of;
    input [2:0] code;
    begin
      case (code)
        3'h0:    period_of = `ODR_P0;
        3'h1:    period_of = `ODR_P1;
        3'h2:    period_of = `ODR_P2;
        3'h3:    period_of = `ODR_P3;
        3'h4:    period_of = `ODR_P4;
        3'h5:    period_of = `ODR_P5;
        3'h6:    period_of = `ODR_P6;
        default: period_of = `ODR_P7;
      endcase
    end
  endfunction

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_WRITE = 3'b010;
  localparam [2:0] ST_READ  = 3'b100;

  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  reg        rst_s1;
  reg        rst_n;
  reg [1:0]  cs_sync;
  reg [2:0]  sclk_sync;
  reg [1:0]  din_sync;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // third stage of sclk only serves the edge detector
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync   <= 2'b11;
      sclk_sync <= 3'b111;
      din_sync  <= 2'b00;
    end else begin
      cs_sync   <= {cs_sync[0], cs_n};
      sclk_sync <= {sclk_sync[1:0], sclk};
      din_sync  <= {din_sync[0], din};
    end
  end

  wire       cs_act  = ~cs_sync[1];
  wire       din_s   = din_sync[1];
  wire       sck_up  = cs_act & sclk_sync[1] & ~sclk_sync[2]; // [R1] [R4]
  wire       sck_dn  = cs_act & ~sclk_sync[1] & sclk_sync[2]; // [R2] [R4]

  // ****************************************
  // register file
  // ****************************************
  reg [2:0]  state;
  reg [4:0]  bit_cnt;
  reg [4:0]  len;
  reg [5:0]  ones;
  reg [23:0] in_shift;
  reg [23:0] out_shift;
  reg [2:0]  sel;
  reg        dir;
  reg [7:0]  setup;
  reg [7:0]  clock_reg;
  reg [15:0] data_reg;
  reg [7:0]  test_reg;
  reg [23:0] offset_mem [0:2];
  reg [23:0] gain_mem   [0:2];
  reg        new_result;
  integer    i;

  wire [7:0]  cmd_next = {in_shift[6:0], din_s};
  wire [23:0] wr_val   = {in_shift[22:0], din_s};
  wire [1:0]  pair     = pair_of(channel_sel);
  wire [1:0]  nx_pair  = pair_of(cmd_next[`CMD_CH_HI:`CMD_CH_LO]);
  wire [2:0]  nx_sel   = cmd_next[`CMD_SEL_HI:`CMD_SEL_LO];
  wire [4:0]  nx_len   = reg_len(nx_sel);
  wire        last_bit = (bit_cnt == len - 5'h01);

  reg  [23:0] rd_val;
  always @* begin
    case (nx_sel) // [R13] [R14]
      `SEL_COMM:   rd_val = {result_ready_n, cmd_next[6:0], 16'h0000}; // [R12]
      `SEL_SETUP:  rd_val = {setup, 16'h0000};
      `SEL_CLOCK:  rd_val = {clock_reg, 16'h0000};
      `SEL_DATA:   rd_val = {data_reg, 8'h00};
      `SEL_TEST:   rd_val = {test_reg, 16'h0000};
      `SEL_OFFSET: rd_val = offset_mem[nx_pair]; // [R18]
      `SEL_GAIN:   rd_val = gain_mem[nx_pair];
      default:     rd_val = 24'h00_0000;
    endcase
  end

  // ****************************************
  // serial protocol engine
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_IDLE; // [R7]
      bit_cnt     <= 5'h00;
      len         <= 5'h00;
      ones        <= 6'h00;
      in_shift    <= 24'h00_0000;
      out_shift   <= 24'h00_0000;
      sel         <= `SEL_COMM;
      dir         <= 1'b0;
      power_down  <= 1'b0;
      channel_sel <= 2'b00;
      setup       <= `RST_SETUP;
      clock_reg   <= `RST_CLOCK;
      test_reg    <= 8'h00;
      dout        <= 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
        offset_mem[i] <= `RST_OFFSET;
        gain_mem[i]   <= `RST_GAIN;
      end
    end else begin
      if (sck_dn) begin
        if (state == ST_READ) begin
          dout      <= out_shift[23]; // [R2] [R3]
          out_shift <= {out_shift[22:0], 1'b0};
        end else begin
          dout <= 1'b1;
        end
      end
      if (sck_up) begin
        ones <= din_s ? ones + 6'h01 : 6'h00;
        if (din_s && ones == `ONES_RESYNC - 6'h01) begin
          state   <= ST_IDLE; // [R10]
          bit_cnt <= 5'h00;
          ones    <= 6'h00;
        end else begin
          case (state)
            ST_IDLE: begin
              if (!(bit_cnt == 5'h00 && din_s)) begin // [R11]
                in_shift <= wr_val; // [R3]
                bit_cnt  <= bit_cnt + 5'h01;
                if (bit_cnt == 5'h07) begin // [R8]
                  bit_cnt     <= 5'h00;
                  sel         <= nx_sel;
                  dir         <= cmd_next[`CMD_DIR_BIT];
                  power_down  <= cmd_next[`CMD_PD_BIT]; // [R16]
                  channel_sel <= cmd_next[`CMD_CH_HI:`CMD_CH_LO]; // [R18]
                  len         <= nx_len; // [R25]
                  out_shift   <= rd_val;
                  if (cmd_next[`CMD_DIR_BIT]) begin // [R15]
                    state <= (nx_len == 5'h00) ? ST_IDLE : ST_READ;
                  end else if (nx_len != 5'h00 && nx_sel != `SEL_COMM) begin
                    state <= ST_WRITE;
                  end
                end
              end
            end
            ST_WRITE: begin
              in_shift <= wr_val;
              bit_cnt  <= bit_cnt + 5'h01;
              if (last_bit) begin
                state   <= ST_IDLE; // [R9]
                bit_cnt <= 5'h00;
                case (sel)
                  `SEL_SETUP:  setup <= wr_val[7:0];
                  `SEL_CLOCK:  clock_reg <= wr_val[7:0] & `CLK_WR_MASK;
                  `SEL_TEST:   test_reg <= wr_val[7:0];
                  `SEL_OFFSET: offset_mem[pair] <= wr_val;
                  `SEL_GAIN:   gain_mem[pair] <= wr_val;
                  default:     test_reg <= test_reg;
                endcase
              end
            end
            ST_READ: begin
              bit_cnt <= bit_cnt + 5'h01;
              if (last_bit) begin
                state   <= ST_IDLE; // [R9] [R25]
                bit_cnt <= 5'h00;
              end
            end
            default: begin
              state   <= ST_IDLE;
              bit_cnt <= 5'h00;
            end
          endcase
        end
      end
    end
  end

  wire data_read_done = sck_up & (state == ST_READ) & (sel == `SEL_DATA) & last_bit
                        & ~(din_s && ones == `ONES_RESYNC - 6'h01);

  // ****************************************
  // conversion timing
  // ****************************************
  reg [15:0] tick_cnt;
  reg [12:0] period_cnt;
  reg [2:0]  settle_cnt;
  wire       sync_hi  = setup[`SETUP_SYNC_BIT];
  wire       stopped  = sync_hi | power_down;
  wire [2:0] rate     = clock_reg[`CLK_RATE_HI:`CLK_RATE_LO]; // [R20]
  wire       tick     = (tick_cnt == CONV_TICK_DIV[15:0] - 16'h0001);
  wire       prd_end  = tick & (period_cnt >= period_of(rate) - 13'h0001);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt        <= 16'h0000;
      period_cnt      <= 13'h0000;
      settle_cnt      <= 3'h0;
      new_result      <= 1'b0;
      data_reg        <= 16'h0000;
      result_ready_n  <= 1'b1;
      modulator_reset <= 1'b1;
      noise_eval      <= 1'b0;
      result_settled  <= 1'b0;
    end else begin
      modulator_reset <= stopped; // [R23]
      noise_eval      <= (channel_sel == 2'b10); // [R19]
      new_result      <= 1'b0;
      if (stopped) begin
        tick_cnt   <= 16'h0000; // [R23]
        period_cnt <= 13'h0000;
        settle_cnt <= `SETTLE_SYNC - 3'h1;
      end else begin
        tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
        if (tick) begin
          period_cnt <= prd_end ? 13'h0000 : period_cnt + 13'h0001;
        end
        // sync-started filter discards two partial periods
        if (prd_end) begin
          if (settle_cnt != 3'h0) begin
            settle_cnt <= settle_cnt - 3'h1; // [R22]
          end else begin
            new_result <= 1'b1;
          end
        end
      end
      // a held or restarted filter is unsettled until its first full result
      if (stopped) begin
        result_settled <= 1'b0; // [R23]
      end else if (new_result) begin
        result_settled <= 1'b1; // [R21] [R22]
      end
      if (new_result) begin
        data_reg       <= conv_result;
        result_ready_n <= 1'b0; // new data wins over a clearing read
      end else if (data_read_done) begin
        result_ready_n <= 1'b1; // [R24]
      end
    end
  end

  // ****************************************
  // clock output and pin enables
  // ****************************************
  reg [7:0] co_cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      co_cnt       <= 8'h00;
      clock_output <= 1'b0;
      dout_oe      <= 1'b0;
    end else begin
      dout_oe <= cs_act; // [R4]
      // power-down does not stop this divider on purpose
      if (clock_reg[`CLK_DIS_BIT]) begin
        co_cnt       <= 8'h00;
        clock_output <= 1'b0;
      end else if (co_cnt == CLOCK_OUTPUT_HALF[7:0] - 8'h01) begin
        co_cnt       <= 8'h00;
        clock_output <= ~clock_output; // [R17]
      end else begin
        co_cnt <= co_cnt + 8'h01;
      end
    end
  end

endmodule
